//--- testbench/acs_mem_model.sv
// data memory holding channel ids and results, plus a comparator on a fixed input level
module acs_mem_model (
  input wire logic sys_clk_i,
  input wire acs_pkg::acs_mem_req_s mem_i,
  input wire logic [11:0] sar_trial_i,
  output logic [15:0] rdata_o,
  output logic cmp_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] ram [256];
  initial
  begin
    for (int i = 0; i < 256; i++)
      ram[i] = {1'b0, 3'(i), 12'h000};
    rdata_o = 16'hFFFF;
  end
  assign cmp_o = (sar_trial_i <= 12'h5A3);
  // read data stand one cycle only; afterwards the bus toggles as a released bus would
  always @(posedge sys_clk_i)
  begin
    if (mem_i.req && mem_i.wr)
      ram[mem_i.addr[7:0]] <= mem_i.wdata;
    if (mem_i.req && !mem_i.wr)
      rdata_o <= ram[mem_i.addr[7:0]];
    else
      rdata_o <= ~rdata_o;
  end
endmodule

//--- testbench/acs_top_chk.sv
// port-level assertions for the converter control block
module acs_top_chk (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] rdata_o,
  input wire logic ext_ref_sel_o,
  input wire logic int_ref_en_o,
  input wire logic conv_power_o,
  input wire logic [3:0] mux_chan_o,
  input wire acs_pkg::acs_mem_req_s mem_o,
  input wire logic port_gate_o,
  input wire logic expanded_data_ram_internal_only_o,
  input wire logic dma_irq_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic dma_on;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ==========================================
  // helper: software view of the dma run request
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      dma_on <= 1'b0;
    else if (wr_i && addr_i == 4'h7)
      dma_on <= wdata_i[0];
  end
  // ==========================================
  // properties
  property p_ext_ref;
    wr_i && addr_i == 4'h0 |=> ext_ref_sel_o == $past(wdata_i[6]);
  endproperty
  a_ext_ref: assert property (p_ext_ref) else $error("reference select wrong");
  property p_int_ref;
    wr_i && addr_i == 4'h0 |=> int_ref_en_o == ($past(wdata_i[1]) && !$past(wdata_i[6]));
  endproperty
  a_int_ref: assert property (p_int_ref) else $error("internal reference wrong");
  property p_power;
    wr_i && addr_i == 4'h0 |=> conv_power_o == $past(wdata_i[7]);
  endproperty
  a_power: assert property (p_power) else $error("power bit wrong");
  property p_coef_hi;
    rd_i && (addr_i == 4'h3 || addr_i == 4'h5) |=> rdata_o[7:6] == 2'b00;
  endproperty
  a_coef_hi: assert property (p_coef_hi) else $error("coefficient high too wide");
  property p_mux;
    wr_i && addr_i == 4'h1 && !dma_on |=> mux_chan_o == $past(wdata_i[3:0]);
  endproperty
  a_mux: assert property (p_mux) else $error("channel not routed");
  property p_gate;
    wr_i && addr_i == 4'h7 && wdata_i[0] |=> ##1 port_gate_o == $past(wdata_i[1], 2);
  endproperty
  a_gate: assert property (p_gate) else $error("port gating wrong");
  property p_expanded_data_ram;
    wr_i && addr_i == 4'h7 && wdata_i[0] |=> ##1
      expanded_data_ram_internal_only_o == $past(wdata_i[1] && wdata_i[2], 2);
  endproperty
  a_expanded_data_ram: assert property (p_expanded_data_ram) else $error("ram limit wrong");
  property p_irq_hold;
    dma_irq_o && !(wr_i && addr_i == 4'h7) |=> dma_irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("done flag dropped");
  property p_release;
    dma_irq_o && $past(dma_irq_o, 2) |-> !port_gate_o && !mem_o.req;
  endproperty
  a_release: assert property (p_release) else $error("activity after block done");
endmodule

bind acs_top acs_top_chk u_acs_top_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
  .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .ext_ref_sel_o(ext_ref_sel_o),
  .int_ref_en_o(int_ref_en_o), .conv_power_o(conv_power_o), .mux_chan_o(mux_chan_o),
  .mem_o(mem_o), .port_gate_o(port_gate_o), .expanded_data_ram_internal_only_o(expanded_data_ram_internal_only_o),
  .dma_irq_o(dma_irq_o)
);

//--- testbench/acs_top_tb.sv
// self-checking bench for the converter control block
module acs_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rst_i, wr_i, rd_i, sar_cmp_i, ext_ref_sel_o, int_ref_en_o, conv_power_o;
  logic sample_o, port_gate_o, expanded_data_ram_internal_only_o, dma_irq_o, sp;
  logic [3:0] addr_i, mux_chan_o;
  logic [7:0] wdata_i, rdata_o, d;
  logic [11:0] sar_trial_o;
  logic [15:0] mem_rdata_i;
  acs_pkg::acs_mem_req_s mem_o;
  logic [3:0] fq [$];
  int err_count, num_checks, nwr, ns, n, cyc;
  time t0, tp, tr, tw, twp, tfirst;

  acs_top u_acs_top (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .ext_ref_sel_o(ext_ref_sel_o),
    .int_ref_en_o(int_ref_en_o), .conv_power_o(conv_power_o), .mux_chan_o(mux_chan_o),
    .sample_o(sample_o), .sar_trial_o(sar_trial_o), .sar_cmp_i(sar_cmp_i), .mem_o(mem_o),
    .mem_rdata_i(mem_rdata_i), .port_gate_o(port_gate_o),
    .expanded_data_ram_internal_only_o(expanded_data_ram_internal_only_o), .dma_irq_o(dma_irq_o));
  acs_mem_model u_acs_mem_model (
    .sys_clk_i(sys_clk_i), .mem_i(mem_o), .sar_trial_i(sar_trial_o),
    .rdata_o(mem_rdata_i), .cmp_o(sar_cmp_i));

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  // ==========================================
  // tasks
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic near(input int got, input int exp, input int tol);
    if (got >= exp - tol && got <= exp + tol)
      got = exp;
    check(got[15:0], exp[15:0]);
  endtask
  task automatic results();
    $display("checks=%0d mismatches=%0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic endtest(input string s);
    $display("test %s finished", s);
  endtask
  // a strobe is lowered and one more edge passes, so calls may follow directly
  task automatic wr_reg(input logic [3:0] a, input logic [7:0] v);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
    @(posedge sys_clk_i);
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [7:0] v);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    @(negedge sys_clk_i);
    v = rdata_o;
    @(posedge sys_clk_i);
  endtask
  task automatic busy_time(input logic [7:0] cmd, output int c);
    wr_reg(4'h2, cmd);
    t0 = $time;
    rd_reg(4'h2, d);
    check(d[7], 1'b1);
    for (n = 0; n < 70000 && d[7] === 1'b1; n++)
      rd_reg(4'h2, d);
    c = int'(($time - t0) / 20);
  endtask
  task automatic wait_irq();
    for (n = 0; n < 2000 && dma_irq_o !== 1'b1; n++)
      @(posedge sys_clk_i);
    check(dma_irq_o, 1'b1);
    // the last result write lands just after the done flag
    repeat (2) @(posedge sys_clk_i);
  endtask
  // ==========================================
  // monitor of sample phases and memory traffic
  always @(posedge sys_clk_i)
  begin
    sp <= sample_o;
    if (sample_o)
      ns = ns + 1;
    if (sample_o && !sp)
    begin
      tp = tr;
      tr = $time;
    end
    if (mem_o.req && !mem_o.wr)
      fq.push_back(u_acs_mem_model.ram[mem_o.addr[7:0]][15:12]);
    if (mem_o.req && mem_o.wr)
    begin
      if (nwr == 0)
        tfirst = $time;
      twp = tw;
      tw = $time;
      nwr++;
      check(mem_o.wdata[15:12], fq.size() > 0 ? fq.pop_front() : 4'hF);
    end
  end
  initial
  begin
    #1_600_000;
    err_count++;
    results();
  end
  // ==========================================
  // tests
  initial
  begin
    rst_i = 1'b1;
    wr_i = 1'b0;
    rd_i = 1'b0;
    addr_i = 4'h0;
    wdata_i = 8'h00;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    check({ext_ref_sel_o, int_ref_en_o}, 2'b00);
    rd_reg(4'h3, d);
    check(d, 8'h20);
    rd_reg(4'h6, d);
    check(d, 8'h00);
    wr_reg(4'h5, 8'hFF);
    rd_reg(4'h5, d);
    check(d, 8'h3F);
    wr_reg(4'h4, 8'hA5);
    rd_reg(4'h4, d);
    check(d, 8'hA5);
    rd_reg(4'hF, d);
    check(d, 8'h00);
    wr_reg(4'h0, 8'h40);
    check({ext_ref_sel_o, int_ref_en_o}, 2'b10);
    wr_reg(4'h0, 8'h02);
    check({ext_ref_sel_o, int_ref_en_o}, 2'b01);
    endtest("registers");
    wr_reg(4'h0, 8'h8C);
    check(conv_power_o, 1'b1);
    ns = 0;
    busy_time(8'h01, cyc);
    near(cyc, 20 * 32, 36);
    near(ns, 5 * 32, 34);
    wr_reg(4'h0, 8'hA0);
    ns = 0;
    busy_time(8'h01, cyc);
    near(cyc, 17 * 8, 12);
    near(ns, 2 * 8, 10);
    wr_reg(4'h0, 8'hA1);
    repeat (450) @(posedge sys_clk_i);
    check(16'((tr - tp) / 20), 16'd136);
    wr_reg(4'h0, 8'hA0);
    repeat (200) @(posedge sys_clk_i);
    endtest("conversion");
    // divide by eight keeps the converter clock in range at this master clock
    wr_reg(4'h1, 8'h0B);
    check(mux_chan_o, 4'hB);
    busy_time(8'h25, cyc);
    near(cyc, 14 * 31 * 17 * 8, 1000);
    wr_reg(4'h1, 8'h0C);
    check(mux_chan_o, 4'hC);
    wr_reg(4'h2, 8'h27);
    repeat (2000) @(posedge sys_clk_i);
    rd_reg(4'h2, d);
    check(d[7], 1'b1);
    rst_i <= 1'b1;
    repeat (16) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    @(posedge sys_clk_i);
    rd_reg(4'h2, d);
    check(d[7], 1'b0);
    endtest("calibration");
    wr_reg(4'h0, 8'hA0);
    wr_reg(4'h8, 8'h03);
    nwr = 0;
    fq.delete();
    wr_reg(4'h7, 8'h07);
    t0 = $time;
    repeat (20) @(posedge sys_clk_i);
    check({port_gate_o, expanded_data_ram_internal_only_o}, 2'b11);
    wait_irq();
    check(nwr[15:0], 16'd4);
    near(int'((tfirst - t0) / 20), 2 * 17 * 8, 8);
    check(16'((tw - twp) / 20), 16'd136);
    check(port_gate_o, 1'b0);
    rd_reg(4'h7, d);
    check({d[3], d[0]}, 2'b10);
    repeat (300) @(posedge sys_clk_i);
    check(nwr[15:0], 16'd4);
    nwr = 0;
    fq.delete();
    wr_reg(4'h7, 8'h01);
    repeat (20) @(posedge sys_clk_i);
    check({port_gate_o, expanded_data_ram_internal_only_o}, 2'b00);
    wait_irq();
    check(nwr[15:0], 16'd4);
    endtest("dma");
    results();
  end
endmodule

//--- verilog/acs_clk_div.sv
// converter clock enable from the master clock, selectable divide ratio
module acs_clk_div (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic run_i,
  input wire logic [1:0] ratio_i,
  output logic tick_o
);
  logic [4:0] cnt;
  logic [4:0] top;
  // 00:/32 01:/2 10:/8 11:/1 ; rate check is software's job
  always_comb
  begin
    case (ratio_i)
      2'b00: top = 5'h1F;
      2'b01: top = 5'h01;
      2'b10: top = 5'h07;
      default: top = 5'h00;
    endcase
  end
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cnt <= 5'h00;
    else if (!run_i || cnt >= top)
      cnt <= 5'h00;
    else
      cnt <= cnt + 5'h01;
  end
  assign tick_o = run_i && (cnt >= top);
endmodule

//--- verilog/acs_corrector.sv
// applies offset and gain coefficients to a raw converter code
module acs_corrector (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic load_i,
  input wire logic [11:0] raw_i,
  input wire logic [13:0] ofs_i,
  input wire logic [13:0] gain_i,
  output logic [11:0] code_o
);
  logic signed [15:0] shifted;
  logic [29:0] scaled;
  logic [17:0] top;
  // midscale coefficient is neutral; larger offset pulls codes down
  always_comb
  begin
    shifted = $signed({4'h0, raw_i}) - $signed({2'b00, ofs_i}) + 16'sh2000;
    if (shifted < 16'sh0000)
      shifted = 16'sh0000;
    scaled = 30'(shifted[15:0]) * 30'(gain_i);
    top = {1'b0, scaled[29:13]};
  end
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      code_o <= 12'h000;
    else if (load_i)
      code_o <= (top > 18'h00FFF) ? 12'hFFF : top[11:0];
  end
endmodule

//--- verilog/acs_map.svh
// register offsets, field positions, reset values and timing counts for the converter control
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
`define ACS_OFS_CFG 4'h0
`define ACS_OFS_CHSEL 4'h1
`define ACS_OFS_CAL 4'h2
`define ACS_OFS_OFSH 4'h3
`define ACS_OFS_OFSL 4'h4
`define ACS_OFS_GAINH 4'h5
`define ACS_OFS_GAINL 4'h6
`define ACS_OFS_DMA_CTRL 4'h7
`define ACS_OFS_DMA_LEN 4'h8
`define ACS_OFS_RESULT_L 4'h9
`define ACS_OFS_RESULT_H 4'hA
`define ACS_CFG_PWR 7
`define ACS_CFG_EXTREF 6
`define ACS_CFG_DIV_HI 5
`define ACS_CFG_DIV_LO 4
`define ACS_CFG_ACQ_HI 3
`define ACS_CFG_ACQ_LO 2
`define ACS_CFG_REFON 1
`define ACS_CFG_CONT 0
`define ACS_CAL_BUSY 7
`define ACS_CAL_START 2
`define ACS_CAL_GAIN 1
`define ACS_CAL_GO 0
`define ACS_CAL_AVG_HI 5
`define ACS_CAL_AVG_LO 4
`define ACS_DMA_RUN 0
`define ACS_DMA_EXT 1
`define ACS_DMA_EXPANDED_DATA_RAM_EN 2
`define ACS_DMA_DONE 3
`define ACS_CH_AGND 4'hB
`define ACS_CH_VREF 4'hC
`define ACS_CFG_RESET 8'h00
`define ACS_OFS_COEF_RESET 14'h2000
`define ACS_GAIN_COEF_RESET 14'h2000
`define ACS_CONV_CLKS 15
`define ACS_SYNC_CLKS 1
`define ACS_CAL_BASE 16
`define ACS_CAL_BITS 14
`endif

//--- verilog/acs_pkg.sv
// types shared by the converter control block
package acs_pkg;
  typedef enum logic [1:0] {
    ACS_IDLE = 2'b00,
    ACS_ACQ = 2'b01,
    ACS_CONV = 2'b10,
    ACS_CAL = 2'b11
  } acs_state_e;
  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } acs_mem_req_s;
  typedef struct packed {
    logic [3:0] chan;
    logic [11:0] code;
  } acs_result_s;
endpackage

//--- verilog/acs_top.sv
// converter sequencer: reference, clocking, timing, DMA pipeline and calibration
// Summary of operation
// - config bit 6 set selects the external reference on the reference pin
// - internal reference stays off after reset until software enables it
// - config bits 5:4 pick the divider; pattern 10 divides by eight
// - writing 8C powers on, divides by 32, four acquisition clocks
// - conversion is 15 clocks plus one sync plus one to four acquisition
// - continuous mode restarts a conversion as soon as one completes
// - DMA runs on the converter clock, one conversion per DMA cycle
// - each cycle converts prior channel, writes prior result, fetches next ID
// - first valid result is written in the third DMA cycle
// - external-target DMA blocks processor port 0 and 2 pin accesses
// - internal-RAM DMA leaves ports 0 and 2 free for the processor
// - processor reaches only on-chip RAM during external-target DMA
// - DMA raises an interrupt when the requested block is filled
// - 14-bit offset and gain coefficients split into 6 high, 8 low bits
// - larger offset coefficient moves the transfer function down
// - larger gain coefficient steepens the transfer function
// - channel codes 1011 and 1100 route ground and reference for calibration
// - 25 starts offset and 27 gain calibration, 31 averages per bit
// - calibration lasts 14 x averages x (16 + acquisition) converter clocks
// - busy bit 7 spans whole calibration, or one conversion normally
//
// Our own choices: the placing of the registers and the strobed register port.
`include "acs_map.svh"
module acs_top (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [3:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  output logic ext_ref_sel_o,
  output logic int_ref_en_o,
  output logic conv_power_o,
  output logic [3:0] mux_chan_o,
  output logic sample_o,
  output logic [11:0] sar_trial_o,
  input wire logic sar_cmp_i,
  output acs_pkg::acs_mem_req_s mem_o,
  input wire logic [15:0] mem_rdata_i,
  output logic port_gate_o,
  output logic expanded_data_ram_internal_only_o,
  output logic dma_irq_o
);
  // ==========================================================
  // registers
  logic [7:0] cfg;
  logic [3:0] chsel;
  logic [6:0] cal_ctl;
  logic [13:0] ofs_coef;
  logic [13:0] gain_coef;
  logic [2:0] dma_ctl;
  logic [7:0] dma_len;
  logic dma_done;
  logic [11:0] result;
  logic tick;
  logic busy;
  logic [7:0] rd_mux;
  acs_pkg::acs_state_e state;
  logic [4:0] phase;
  logic [11:0] sar;
  logic [11:0] corr_code;
  logic corr_load;
  logic conv_done;
  logic [4:0] acq_clks;
  logic [4:0] avg_n;
  logic [13:0] cal_bit;
  logic [4:0] cal_avg;
  logic [4:0] cal_ones;
  logic start_single;
  logic [3:0] conv_chan;
  logic dma_run;
  logic [1:0] dma_fill;
  logic [7:0] dma_idx;
  logic [3:0] next_chan;
  logic [3:0] prev_chan;
  logic wr_pend;
  logic fetch_q;
  logic [3:0] id_buf;
  logic dma_start;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign acq_clks = {3'b000, cfg[`ACS_CFG_ACQ_HI:`ACS_CFG_ACQ_LO]} + 5'h01;
  // average count field: 10 gives 31, others fewer
  always_comb
  begin
    case (cal_ctl[`ACS_CAL_AVG_HI:`ACS_CAL_AVG_LO])
      2'b00: avg_n = 5'h0F;
      2'b01: avg_n = 5'h01;
      2'b10: avg_n = 5'h1F;
      default: avg_n = 5'h03;
    endcase
  end

  // ==========================================================
  // register writes
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cfg <= `ACS_CFG_RESET;
      chsel <= 4'h0;
      ofs_coef <= `ACS_OFS_COEF_RESET;
      gain_coef <= `ACS_GAIN_COEF_RESET;
      dma_len <= 8'h00;
    end
    else if (wr_i)
    begin
      if (hit(addr_i, `ACS_OFS_CFG))
        cfg <= wdata_i;
      if (hit(addr_i, `ACS_OFS_CHSEL))
        chsel <= wdata_i[3:0];
      if (hit(addr_i, `ACS_OFS_OFSH))
        ofs_coef[13:8] <= wdata_i[5:0];
      if (hit(addr_i, `ACS_OFS_OFSL))
        ofs_coef[7:0] <= wdata_i;
      if (hit(addr_i, `ACS_OFS_GAINH))
        gain_coef[13:8] <= wdata_i[5:0];
      if (hit(addr_i, `ACS_OFS_GAINL))
        gain_coef[7:0] <= wdata_i;
      if (hit(addr_i, `ACS_OFS_DMA_LEN))
        dma_len <= wdata_i;
    end
    else if (state == acs_pkg::ACS_CAL && tick && phase == 5'h00 && cal_avg == avg_n
             && cal_bit != 14'h0000)
    begin
      // majority of averaged comparisons decides each coefficient bit
      if (cal_ctl[`ACS_CAL_GAIN])
        gain_coef <= gain_coef | ((cal_ones > (avg_n >> 1)) ? cal_bit : 14'h0000);
      else
        ofs_coef <= ofs_coef | ((cal_ones > (avg_n >> 1)) ? cal_bit : 14'h0000);
    end
  end

  assign ext_ref_sel_o = cfg[`ACS_CFG_EXTREF];
  assign int_ref_en_o = cfg[`ACS_CFG_REFON] && !cfg[`ACS_CFG_EXTREF];
  assign conv_power_o = cfg[`ACS_CFG_PWR];

  acs_clk_div u_div (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .run_i(cfg[`ACS_CFG_PWR]),
    .ratio_i(cfg[`ACS_CFG_DIV_HI:`ACS_CFG_DIV_LO]),
    .tick_o(tick)
  );

  // ==========================================================
  // control register: start and busy
  assign start_single = wr_i && hit(addr_i, `ACS_OFS_CAL) && wdata_i[`ACS_CAL_GO];
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      cal_ctl <= 7'h00;
    else if (wr_i && hit(addr_i, `ACS_OFS_CAL))
      cal_ctl <= wdata_i[6:0];
    else if (conv_done)
      cal_ctl[`ACS_CAL_START] <= 1'b0;
  end
  assign busy = (state != acs_pkg::ACS_IDLE);

  // ==========================================================
  // conversion sequencer, steps once per converter clock
  assign conv_chan = dma_run ? next_chan : chsel;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state <= acs_pkg::ACS_IDLE;
      phase <= 5'h00;
      sar <= 12'h000;
      conv_done <= 1'b0;
      cal_bit <= 14'h0000;
      cal_avg <= 5'h00;
      cal_ones <= 5'h00;
    end
    else
    begin
      conv_done <= 1'b0;
      case (state)
        acs_pkg::ACS_IDLE:
        begin
          phase <= 5'h00;
          if (wr_i && hit(addr_i, `ACS_OFS_CAL) && wdata_i[`ACS_CAL_START])
          begin
            state <= acs_pkg::ACS_CAL;
            cal_bit <= 14'h2000;
            cal_avg <= 5'h00;
            cal_ones <= 5'h00;
          end
          else if (start_single || cfg[`ACS_CFG_CONT] || dma_run)
            state <= acs_pkg::ACS_ACQ;
        end
        acs_pkg::ACS_ACQ:
          if (tick)
          begin
            // one sync clock plus the acquisition clocks
            if (phase == acq_clks + 5'(`ACS_SYNC_CLKS) - 5'h01)
            begin
              phase <= 5'h00;
              sar <= 12'h800;
              state <= acs_pkg::ACS_CONV;
            end
            else
              phase <= phase + 5'h01;
          end
        acs_pkg::ACS_CONV:
          if (tick)
          begin
            if (phase < 5'd12)
              sar <= (sar & ~(12'h800 >> phase) | (sar_cmp_i ? (12'h800 >> phase) : 12'h000))
                     | ((phase < 5'd11) ? (12'h400 >> phase) : 12'h000);
            if (phase == 5'(`ACS_CONV_CLKS) - 5'h01)
            begin
              phase <= 5'h00;
              conv_done <= 1'b1;
              // continuous and DMA modes chain straight into the next sample
              state <= (cfg[`ACS_CFG_CONT] || dma_run) ? acs_pkg::ACS_ACQ
                       : acs_pkg::ACS_IDLE;
            end
            else
              phase <= phase + 5'h01;
          end
        acs_pkg::ACS_CAL:
          if (tick)
          begin
            // each coefficient bit: avg_n trials of (16 + acquisition) clocks
            if (phase == 5'(`ACS_CAL_BASE) + acq_clks - 5'h01)
            begin
              phase <= 5'h00;
              cal_ones <= cal_ones + {4'h0, sar_cmp_i};
              cal_avg <= cal_avg + 5'h01;
            end
            else if (phase == 5'h00 && cal_avg == avg_n)
            begin
              cal_avg <= 5'h00;
              cal_ones <= 5'h00;
              cal_bit <= cal_bit >> 1;
              if (cal_bit == 14'h0001)
              begin
                state <= acs_pkg::ACS_IDLE;
                conv_done <= 1'b1;
              end
            end
            else
              phase <= phase + 5'h01;
          end
        default:
          state <= acs_pkg::ACS_IDLE;
      endcase
    end
  end

  // during calibration the mux follows chsel only for codes other than ground and reference; those take conv_chan, which is next_chan while DMA runs
  assign mux_chan_o = (state == acs_pkg::ACS_CAL && chsel != `ACS_CH_AGND
                       && chsel != `ACS_CH_VREF) ? chsel : conv_chan;
  assign sample_o = (state == acs_pkg::ACS_ACQ);
  assign sar_trial_o = sar;
  assign corr_load = conv_done && state != acs_pkg::ACS_CAL;

  acs_corrector u_corr (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .load_i(corr_load),
    .raw_i(sar),
    .ofs_i(ofs_coef),
    .gain_i(gain_coef),
    .code_o(corr_code)
  );

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      result <= 12'h000;
    else
      result <= corr_code;
  end

  // ==========================================================
  // DMA pipeline: one stage step per completed conversion
  logic step;
  assign step = conv_done && dma_run;
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      dma_ctl <= 3'b000;
      dma_done <= 1'b0;
      dma_fill <= 2'b00;
      dma_idx <= 8'h00;
      next_chan <= 4'h0;
      prev_chan <= 4'h0;
      wr_pend <= 1'b0;
    end
    else
    begin
      wr_pend <= step && (dma_fill != 2'b00);
      if (wr_i && hit(addr_i, `ACS_OFS_DMA_CTRL))
      begin
        dma_ctl <= wdata_i[2:0];
        dma_fill <= 2'b00;
        dma_idx <= 8'h00;
        if (wdata_i[`ACS_DMA_RUN])
          dma_done <= 1'b0;
      end
      else if (step)
      begin
        prev_chan <= next_chan;
        next_chan <= id_buf;
        if (dma_fill != 2'b11)
          dma_fill <= dma_fill + 2'b01;
        if (dma_fill != 2'b00)
        begin
          dma_idx <= dma_idx + 8'h01;
          if (dma_idx == dma_len)
          begin
            dma_ctl[`ACS_DMA_RUN] <= 1'b0;
            dma_done <= 1'b1;
          end
        end
      end
    end
  end
  assign dma_run = dma_ctl[`ACS_DMA_RUN];

  // the fetched id stands for one cycle only, so it is caught the cycle after the request
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      fetch_q <= 1'b0;
      id_buf <= 4'h0;
    end
    else
    begin
      fetch_q <= mem_o.req && !mem_o.wr;
      if (fetch_q)
        id_buf <= mem_rdata_i[15:12];
    end
  end

  // write waits one cycle after the step so the corrected code is in place;
  // the first id is fetched as DMA starts
  assign dma_start = wr_i && hit(addr_i, `ACS_OFS_DMA_CTRL) && wdata_i[`ACS_DMA_RUN];
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      mem_o <= '0;
    else if (wr_pend)
    begin
      mem_o.req <= 1'b1;
      mem_o.wr <= 1'b1;
      mem_o.addr <= {7'h00, dma_idx - 8'h01, 1'b0};
      mem_o.wdata <= {prev_chan, corr_code};
    end
    else if (dma_start || (dma_run && (mem_o.wr || (step && dma_fill == 2'b00))))
    begin
      mem_o.req <= 1'b1;
      mem_o.wr <= 1'b0;
      mem_o.addr <= {7'h00, dma_start ? 8'h00 : dma_idx, 1'b1};
      mem_o.wdata <= 16'h0000;
    end
    else
      mem_o <= '0;
  end

  assign port_gate_o = dma_run && dma_ctl[`ACS_DMA_EXT];
  assign expanded_data_ram_internal_only_o = port_gate_o && dma_ctl[`ACS_DMA_EXPANDED_DATA_RAM_EN];
  assign dma_irq_o = dma_done;

  // ==========================================================
  // register reads, data in the cycle after the strobe
  always_comb
  begin
    case (addr_i)
      `ACS_OFS_CFG: rd_mux = cfg;
      `ACS_OFS_CHSEL: rd_mux = {4'h0, chsel};
      `ACS_OFS_CAL: rd_mux = {busy, cal_ctl};
      `ACS_OFS_OFSH: rd_mux = {2'b00, ofs_coef[13:8]};
      `ACS_OFS_OFSL: rd_mux = ofs_coef[7:0];
      `ACS_OFS_GAINH: rd_mux = {2'b00, gain_coef[13:8]};
      `ACS_OFS_GAINL: rd_mux = gain_coef[7:0];
      `ACS_OFS_DMA_CTRL: rd_mux = {4'h0, dma_done, dma_ctl};
      `ACS_OFS_DMA_LEN: rd_mux = dma_len;
      `ACS_OFS_RESULT_L: rd_mux = result[7:0];
      `ACS_OFS_RESULT_H: rd_mux = {4'h0, result[11:8]};
      default: rd_mux = 8'h00;
    endcase
  end
  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
      rdata_o <= 8'h00;
    else if (rd_i)
      rdata_o <= rd_mux;
    else
      rdata_o <= 8'h00;
  end
endmodule
